// ==== design/atc_pkg.sv ====
// Types shared by the async timer design
package atc_pkg;

  // ========================================================================
  // Control register A layout
  typedef struct packed {
    logic force_compare_strobe;
    logic wgm_hi;
    logic [1:0] compare_output_mode;
    logic wgm_lo;
    logic [2:0] clock_select;
  } atc_ctl_type;

  // ========================================================================
  // Waveform modes
  typedef enum logic [1:0] {
    wv_normal,
    wv_phase_pwm,
    wv_clear_on_match,
    wv_fast_pwm
  } atc_wave_type;

  // ========================================================================
  // Pin controls toward the oscillator pads
  typedef struct packed {
    logic port_detach;
    logic osc_enable;
    logic ext_clk_buf_en;
  } atc_pad_type;

endpackage

// ==== design/atc_regs.svh ====
// Register map, field positions, reset values and timing counts of the async timer
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// ==========================================================================
// Register byte offsets
`define ATC_OFS_CONTROL_A 5'h00
`define ATC_OFS_COUNT 5'h04
`define ATC_OFS_COMPARE 5'h08
`define ATC_OFS_IRQ_MASK 5'h0c
`define ATC_OFS_FLAGS 5'h10
`define ATC_OFS_ASYNC_STATUS 5'h14
`define ATC_OFS_GEN_CONTROL 5'h18

// ==========================================================================
// Field positions
`define ATC_BIT_FORCE 7
`define ATC_BIT_OVF 0
`define ATC_BIT_CMP 1
`define ATC_BIT_CTL_BUSY 0
`define ATC_BIT_CMP_BUSY 1
`define ATC_BIT_CNT_BUSY 2
`define ATC_BIT_ASYNC_SEL 3
`define ATC_BIT_EXT_CLK 4
`define ATC_BIT_PRESCALER_RESET 0

// ==========================================================================
// Reset values and counter limits
`define ATC_RST_BYTE 8'h00
`define ATC_RST_MASK 2'h0
`define ATC_TOP_MAX 8'hff
`define ATC_BOTTOM 8'h00

// ==========================================================================
// Holding channels
`define ATC_CH_CONTROL 0
`define ATC_CH_COUNT 1
`define ATC_CH_COMPARE 2
`define ATC_NUM_CH 3

// ==========================================================================
// Timing counts
`define ATC_OSC_EDGES_TO_LATCH 2
`define ATC_FLAG_SYNC_CYCLES 3

// ==========================================================================
// Sleep mode codes on sleep_mode_in
`define ATC_SLEEP_NONE 3'h0
`define ATC_SLEEP_IDLE 3'h1
`define ATC_SLEEP_NOISE 3'h2
`define ATC_SLEEP_POWER_DOWN 3'h3
`define ATC_SLEEP_POWER_SAVE 3'h4
`define ATC_SLEEP_STANDBY 3'h5

`endif

// ==== design/atc_sync2.sv ====
// Two flip-flop synchroniser for levels entering the clock domain
`timescale 1ns/1ps

module atc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in, // Destination clock
  input wire logic rst_in, // Async reset, active high
  input wire logic [WIDTH-1:0] d_in, // Asynchronous level
  output logic [WIDTH-1:0] q_out // Synchronised level
);

  logic [WIDTH-1:0] meta_reg;

  // ========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end

endmodule

// ==== design/atc_timer.sv ====
// 8-bit timer/counter with I/O clock or oscillator-pin clocking, Avalon-MM slave
`timescale 1ns/1ps
`include "atc_regs.svh"

module atc_timer import atc_pkg::*; #(
  parameter int PRE_W = 10
) (
  input wire logic ref_clk_in, // System I/O clock, 200 MHz
  input wire logic rst_in, // Async reset, active high
  input wire logic [4:0] avs_address_in, // Byte address
  input wire logic avs_read_in, // Read request
  input wire logic avs_write_in, // Write request
  input wire logic [31:0] avs_writedata_in, // Write data
  input wire logic [3:0] avs_byteenable_in, // Byte enables, lane 0 used
  output logic [31:0] avs_readdata_out, // Read data
  output logic avs_waitrequest_out, // Wait request
  input wire logic osc_pin_in, // Oscillator input pin level
  input wire logic [2:0] sleep_mode_in, // Current sleep mode
  output logic compare_output_pin_out, // Compare output level
  output logic compare_output_oe_out, // Compare output drives pin
  output atc_pad_type pad_ctl_out, // Oscillator pad controls
  output logic irq_compare_out, // Compare interrupt request
  output logic irq_overflow_out, // Overflow interrupt request
  output logic wake_out // Wake-up pulse
);

  // ========================================================================
  // Helpers
  function automatic atc_wave_type wave_of(input atc_ctl_type c);
    case ({c.wgm_hi, c.wgm_lo})
      2'b00: wave_of = wv_normal;
      2'b01: wave_of = wv_phase_pwm;
      2'b10: wave_of = wv_clear_on_match;
      default: wave_of = wv_fast_pwm;
    endcase
  endfunction

  function automatic logic [PRE_W-1:0] div_mask(input logic [2:0] cs);
    case (cs)
      3'h2: div_mask = PRE_W'(10'h007);
      3'h3: div_mask = PRE_W'(10'h01f);
      3'h4: div_mask = PRE_W'(10'h03f);
      3'h5: div_mask = PRE_W'(10'h07f);
      3'h6: div_mask = PRE_W'(10'h0ff);
      3'h7: div_mask = PRE_W'(10'h3ff);
      default: div_mask = '0;
    endcase
  endfunction

  function automatic logic is_pwm(input atc_wave_type w);
    is_pwm = (w == wv_phase_pwm) || (w == wv_fast_pwm);
  endfunction

  // ========================================================================
  // Avalon-MM slave: one wait cycle, then answer
  logic resp_reg;
  logic wr_en;
  logic [7:0] wbyte;

  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !resp_reg;
  assign wr_en = avs_write_in && resp_reg && avs_byteenable_in[0];
  assign wbyte = avs_writedata_in[7:0];

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      resp_reg <= 1'b0;
    end else begin
      resp_reg <= (avs_read_in || avs_write_in) && !resp_reg;
    end
  end

  logic wr_ctl;
  logic wr_cnt;
  logic wr_cmp;
  logic wr_mask;
  logic wr_flags;
  logic wr_asr;
  logic wr_gen;
  assign wr_ctl = wr_en && (avs_address_in == `ATC_OFS_CONTROL_A);
  assign wr_cnt = wr_en && (avs_address_in == `ATC_OFS_COUNT);
  assign wr_cmp = wr_en && (avs_address_in == `ATC_OFS_COMPARE);
  assign wr_mask = wr_en && (avs_address_in == `ATC_OFS_IRQ_MASK);
  assign wr_flags = wr_en && (avs_address_in == `ATC_OFS_FLAGS);
  assign wr_asr = wr_en && (avs_address_in == `ATC_OFS_ASYNC_STATUS);
  assign wr_gen = wr_en && (avs_address_in == `ATC_OFS_GEN_CONTROL);

  // ========================================================================
  // Async status bits
  logic async_sel_reg;
  logic ext_clk_reg;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      async_sel_reg <= 1'b0;
      ext_clk_reg <= 1'b0;
    end else if (wr_asr) begin
      // No repair of timer contents on a source change
      async_sel_reg <= wbyte[`ATC_BIT_ASYNC_SEL];
      ext_clk_reg <= wbyte[`ATC_BIT_EXT_CLK];
    end
  end

  // Pads: oscillator runs only for async crystal clocking, and stops in power-down and standby
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pad_ctl_out <= '0;
    end else begin
      pad_ctl_out.port_detach <= async_sel_reg;
      pad_ctl_out.osc_enable <= async_sel_reg && !ext_clk_reg && (sleep_mode_in != `ATC_SLEEP_POWER_DOWN)
                                && (sleep_mode_in != `ATC_SLEEP_STANDBY);
      pad_ctl_out.ext_clk_buf_en <= async_sel_reg && ext_clk_reg;
    end
  end

  // ========================================================================
  // Oscillator edge detection, pin sampled by two flops first
  logic osc_s;
  logic osc_d_reg;
  logic osc_rise;

  atc_sync2 #(.WIDTH(1)) u_osc_sync (
    .clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in(osc_pin_in),
    .q_out(osc_s)
  );

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_d_reg <= 1'b0;
    end else begin
      osc_d_reg <= osc_s;
    end
  end
  // Edges are only seen reliably with CPU clock above four times osc
  assign osc_rise = osc_s && !osc_d_reg;

  // ========================================================================
  // Holding registers, one per destination
  logic [`ATC_NUM_CH-1:0] ch_wr;
  logic [`ATC_NUM_CH-1:0] busy;
  logic [`ATC_NUM_CH-1:0] xfer;
  assign ch_wr = {wr_cmp, wr_cnt, wr_ctl};

  for (genvar i = 0; i < `ATC_NUM_CH; i++) begin : g_hold
    logic [7:0] hold_reg;
    logic busy_reg;
    logic [1:0] edge_reg;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
        hold_reg <= `ATC_RST_BYTE;
        busy_reg <= 1'b0;
        edge_reg <= 2'h0;
      end else if (ch_wr[i] && async_sel_reg) begin
        // A rewrite while busy restarts the transfer
        hold_reg <= wbyte;
        busy_reg <= 1'b1;
        edge_reg <= 2'h0;
      end else if (busy_reg && osc_rise) begin
        if (edge_reg == 2'(`ATC_OSC_EDGES_TO_LATCH - 1)) begin
          busy_reg <= 1'b0;
        end
        edge_reg <= edge_reg + 2'h1;
      end
    end
    assign busy[i] = busy_reg;
    assign xfer[i] = busy_reg && osc_rise && (edge_reg == 2'(`ATC_OSC_EDGES_TO_LATCH - 1));
  end

  // ========================================================================
  // Control register A and force strobe
  atc_ctl_type ctl_reg;
  atc_wave_type wave;
  logic force_reg;
  assign wave = wave_of(ctl_reg);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_reg <= '0;
      force_reg <= 1'b0;
    end else begin
      force_reg <= 1'b0;
      if (xfer[`ATC_CH_CONTROL]) begin
        ctl_reg <= atc_ctl_type'({1'b0, g_hold[`ATC_CH_CONTROL].hold_reg[6:0]});
        force_reg <= g_hold[`ATC_CH_CONTROL].hold_reg[`ATC_BIT_FORCE];
      end else if (wr_ctl && !async_sel_reg) begin
        ctl_reg <= atc_ctl_type'({1'b0, wbyte[6:0]}); // Strobe never stored
        force_reg <= wbyte[`ATC_BIT_FORCE];
      end
    end
  end

  // ========================================================================
  // Prescaler and timer tick
  logic [PRE_W-1:0] pre_reg;
  logic src_tick;
  logic tick;
  logic pre_clr;
  assign pre_clr = wr_gen && wbyte[`ATC_BIT_PRESCALER_RESET];
  assign src_tick = async_sel_reg ? osc_rise : 1'b1;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_reg <= '0;
    end else if (pre_clr) begin
      pre_reg <= '0;
    end else if (src_tick) begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  // Tick is an enable, never a clock
  assign tick = (ctl_reg.clock_select != 3'h0) && src_tick && !pre_clr
                && ((pre_reg & div_mask(ctl_reg.clock_select)) == div_mask(ctl_reg.clock_select));

  // ========================================================================
  // Counter and compare
  logic [7:0] count_reg;
  logic [7:0] cmp_reg;
  logic [7:0] cmp_act_reg;
  logic up_reg;
  logic block_reg;
  logic cnt_load;
  logic [7:0] cnt_load_val;
  logic at_max;
  logic match_evt;
  logic ovf_evt;

  assign cnt_load = xfer[`ATC_CH_COUNT] || (wr_cnt && !async_sel_reg);
  assign cnt_load_val = xfer[`ATC_CH_COUNT] ? g_hold[`ATC_CH_COUNT].hold_reg : wbyte;
  assign at_max = (count_reg == `ATC_TOP_MAX);
  assign match_evt = tick && !cnt_load && (count_reg == cmp_act_reg) && !block_reg
                     && !busy[`ATC_CH_COUNT] && !busy[`ATC_CH_COMPARE];
  assign ovf_evt = tick && !cnt_load && ((wave == wv_phase_pwm) ? (count_reg == `ATC_BOTTOM && !up_reg) : at_max);

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= `ATC_RST_BYTE;
      up_reg <= 1'b1;
    end else if (cnt_load) begin
      count_reg <= cnt_load_val;
    end else if (tick) begin
      case (wave)
        wv_clear_on_match: count_reg <= (count_reg == cmp_act_reg) ? `ATC_BOTTOM : count_reg + 8'h01;
        wv_phase_pwm: begin
          if (up_reg && at_max) begin
            up_reg <= 1'b0;
            count_reg <= count_reg - 8'h01;
          end else if (!up_reg && count_reg == `ATC_BOTTOM) begin
            up_reg <= 1'b1;
            count_reg <= count_reg + 8'h01;
          end else begin
            count_reg <= up_reg ? count_reg + 8'h01 : count_reg - 8'h01;
          end
        end
        default: count_reg <= count_reg + 8'h01;
      endcase
    end
  end

  // A counter write hides the match on the following tick
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      block_reg <= 1'b0;
    end else if (cnt_load) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // PWM modes double-buffer the compare value; both update at the MAX tick
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmp_reg <= `ATC_RST_BYTE;
      cmp_act_reg <= `ATC_RST_BYTE;
    end else begin
      if (xfer[`ATC_CH_COMPARE]) begin
        cmp_reg <= g_hold[`ATC_CH_COMPARE].hold_reg;
      end else if (wr_cmp && !async_sel_reg) begin
        cmp_reg <= wbyte;
      end
      if (!is_pwm(wave) || (tick && at_max)) begin
        cmp_act_reg <= cmp_reg;
      end
    end
  end

  // ========================================================================
  // Compare output, changed on the matching tick, at the MAX tick in fast PWM, or by the force strobe in non-PWM modes
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      compare_output_pin_out <= 1'b0;
    end else begin
      case (wave)
        wv_normal, wv_clear_on_match: begin
          if (match_evt || force_reg) begin
            case (ctl_reg.compare_output_mode)
              2'h1: compare_output_pin_out <= !compare_output_pin_out;
              2'h2: compare_output_pin_out <= 1'b0;
              2'h3: compare_output_pin_out <= 1'b1;
              default: compare_output_pin_out <= compare_output_pin_out;
            endcase
          end
        end
        wv_fast_pwm: begin
          if (ctl_reg.compare_output_mode[1]) begin
            if (tick && at_max) begin
              compare_output_pin_out <= !ctl_reg.compare_output_mode[0];
            end else if (match_evt) begin
              compare_output_pin_out <= ctl_reg.compare_output_mode[0];
            end
          end
        end
        default: begin
          if (ctl_reg.compare_output_mode[1] && match_evt) begin
            compare_output_pin_out <= ctl_reg.compare_output_mode[0] ^ !up_reg;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      compare_output_oe_out <= 1'b0;
    end else begin
      compare_output_oe_out <= (ctl_reg.compare_output_mode != 2'h0);
    end
  end

  // ========================================================================
  // Interrupt flags: async events delayed by the sync pipeline
  logic [1:0] evt;
  logic [`ATC_FLAG_SYNC_CYCLES-1:0][1:0] fsync_reg;
  logic [1:0] flag_set;
  logic [1:0] flags_reg;
  logic [1:0] mask_reg;
  assign evt = {match_evt, ovf_evt}; // Forced matches never reach here
  assign flag_set = async_sel_reg ? fsync_reg[`ATC_FLAG_SYNC_CYCLES-1] : evt;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fsync_reg <= '0;
    end else begin
      fsync_reg <= {fsync_reg[`ATC_FLAG_SYNC_CYCLES-2:0], evt};
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_reg <= 2'h0;
    end else begin
      flags_reg <= (flags_reg & ~(wr_flags ? wbyte[1:0] : 2'h0)) | flag_set;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mask_reg <= `ATC_RST_MASK;
    end else if (wr_mask) begin
      mask_reg <= wbyte[1:0];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_compare_out <= 1'b0;
      irq_overflow_out <= 1'b0;
    end else begin
      irq_compare_out <= flags_reg[`ATC_BIT_CMP] && mask_reg[`ATC_BIT_CMP];
      irq_overflow_out <= flags_reg[`ATC_BIT_OVF] && mask_reg[`ATC_BIT_OVF];
    end
  end

  // ========================================================================
  // Wake-up from power-save or noise reduction
  logic light_sleep;
  logic wake_pend_reg;
  logic armed_reg;
  logic wake_step;
  assign light_sleep = (sleep_mode_in == `ATC_SLEEP_POWER_SAVE) || (sleep_mode_in == `ATC_SLEEP_NOISE);
  assign wake_step = async_sel_reg ? osc_rise : 1'b1;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_pend_reg <= 1'b0;
      armed_reg <= 1'b1;
      wake_out <= 1'b0;
    end else begin
      wake_out <= 1'b0;
      if (wake_pend_reg && wake_step) begin
        wake_out <= 1'b1;
        wake_pend_reg <= 1'b0;
        armed_reg <= 1'b0;
      end else if (!armed_reg && osc_rise) begin
        armed_reg <= 1'b1;
      end else if (armed_reg && light_sleep && |(flags_reg & mask_reg)) begin
        wake_pend_reg <= 1'b1;
      end
    end
  end

  // ========================================================================
  // Count readout, refreshed on each osc edge in async mode
  logic [7:0] count_view_reg;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_view_reg <= `ATC_RST_BYTE;
    end else if (!async_sel_reg || osc_rise) begin
      count_view_reg <= count_reg;
    end
  end

  // ========================================================================
  // Read data, loaded in the wait cycle
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !resp_reg) begin
      case (avs_address_in)
        `ATC_OFS_CONTROL_A: avs_readdata_out <= {24'h00_0000, 1'b0, ctl_reg[6:0]};
        `ATC_OFS_COUNT: avs_readdata_out <= {24'h00_0000, count_view_reg};
        `ATC_OFS_COMPARE: avs_readdata_out <= {24'h00_0000, cmp_reg};
        `ATC_OFS_IRQ_MASK: avs_readdata_out <= {30'h0000_0000, mask_reg};
        `ATC_OFS_FLAGS: avs_readdata_out <= {30'h0000_0000, flags_reg};
        `ATC_OFS_ASYNC_STATUS: avs_readdata_out <= {27'h000_0000, ext_clk_reg, async_sel_reg,
          busy[`ATC_CH_COUNT], busy[`ATC_CH_COMPARE], busy[`ATC_CH_CONTROL]};
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ==== test/atc_timer_asserts.sv ====
// Port-level checks for the async timer
`timescale 1ns/1ps
`include "atc_regs.svh"
module atc_timer_asserts import atc_pkg::*; (
  input wire logic ref_clk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic [4:0] avs_address_in, // Address
  input wire logic avs_read_in, // Read
  input wire logic avs_write_in, // Write
  input wire logic [31:0] avs_writedata_in, // Wdata
  input wire logic [3:0] avs_byteenable_in, // Lanes
  input wire logic [31:0] avs_readdata_out, // Rdata
  input wire logic avs_waitrequest_out, // Wait
  input wire logic osc_pin_in, // Osc pin
  input wire logic [2:0] sleep_mode_in, // Sleep
  input wire logic compare_output_pin_out, // Pin
  input wire logic compare_output_oe_out, // Oe
  input wire atc_pad_type pad_ctl_out, // Pads
  input wire logic irq_compare_out, // Cmp irq
  input wire logic irq_overflow_out, // Ovf irq
  input wire logic wake_out // Wake
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ==========
  // Bus
  sequence s_rd_done;
    avs_read_in && !avs_waitrequest_out;
  endsequence
  a_wait_one_cycle: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait held too long");
  a_wait_idle_low: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
    else $error("wait without request");
  a_force_reads_zero: assert property (s_rd_done ##0 avs_address_in == 5'h00 |-> !avs_readdata_out[7])
    else $error("strobe read back set");
  a_upper_bits_zero: assert property (s_rd_done |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (s_rd_done ##0 avs_address_in == 5'h1c |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  // ==========
  // Events
  a_wake_single_pulse: assert property (wake_out |=> !wake_out [*3])
    else $error("wake rearmed too soon");
  a_osc_off_deep: assert property ($past(sleep_mode_in) inside {3'h3, 3'h5} |-> !pad_ctl_out.osc_enable)
    else $error("oscillator on in deep sleep");
  a_ovf_clear_cause: assert property ($fell(irq_overflow_out) |-> $past(avs_write_in) || $past(avs_write_in, 2))
    else $error("overflow irq dropped alone");
  a_cmp_clear_cause: assert property ($fell(irq_compare_out) |-> $past(avs_write_in) || $past(avs_write_in, 2))
    else $error("compare irq dropped alone");
endmodule

// ==== test/tb_atc_timer.sv ====
// Self-checking bench for the async timer
`timescale 1ns/1ps
`include "atc_regs.svh"
module tb_atc_timer import atc_pkg::*;;
  logic ref_clk_in = 0, rst_in = 1, avs_read_in = 0, avs_write_in = 0, osc_pin_in = 0, osc_run = 0;
  logic [4:0] avs_address_in = 0;
  logic [31:0] avs_writedata_in = 0, avs_readdata_out;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [2:0] sleep_mode_in = 0;
  logic avs_waitrequest_out, compare_output_pin_out, compare_output_oe_out, irq_compare_out, irq_overflow_out, wake_out;
  atc_pad_type pad_ctl_out;
  logic [7:0] q, r, p;
  int errors = 0, n_tests = 0, cyc = 0, oc = 0;
  time t0;
  atc_timer dut_u (.*);
  initial begin
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  // Osc pin period of 40 cycles keeps the CPU clock well above four times it
  // Crystal model: the pin stands still while the pad oscillator is off
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (osc_run && pad_ctl_out.osc_enable) oc <= (oc == 19) ? 0 : oc + 1;
    if (osc_run && pad_ctl_out.osc_enable && oc == 19) osc_pin_in <= !osc_pin_in;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    avs_address_in <= a;
    avs_writedata_in <= {24'h0, d};
    avs_write_in <= w;
    avs_read_in <= !w;
    // Only the cycle ceiling ends a stuck wait
    do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out[7:0];
    avs_write_in <= 0;
    avs_read_in <= 0;
    @(posedge ref_clk_in);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int div(input int cs);
    return cs == 2 ? 8 : cs == 3 ? 32 : cs == 4 ? 64 : cs == 5 ? 128 : cs == 6 ? 256 : 1024;
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h1b18));
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 0;
    @(posedge ref_clk_in);
    chk({5'h0, pad_ctl_out}, 8'h00);
    for (int a = 0; a < 8; a++) begin
      bus(0, 5'(a * 4), 8'h00);
      chk(q, 8'h00);
    end
    $display("reset values done");
    for (int cs = 2; cs < 8; cs++) begin
      bus(1, `ATC_OFS_COUNT, 8'h00);
      bus(1, `ATC_OFS_GEN_CONTROL, 8'h01);
      bus(1, `ATC_OFS_CONTROL_A, 8'(cs));
      repeat (4 * div(cs)) @(posedge ref_clk_in);
      bus(1, `ATC_OFS_CONTROL_A, 8'h00);
      bus(0, `ATC_OFS_COUNT, 8'h00);
      chk(8'(q >= 3 && q <= 6), 8'h01);
    end
    $display("prescaler done");
    r = q;
    for (int i = 0; i < 2; i++) begin
      p = {7'h0, compare_output_pin_out};
      bus(1, `ATC_OFS_CONTROL_A, i ? 8'hd0 : 8'h90);
      repeat (3) @(posedge ref_clk_in);
      chk({7'h0, compare_output_pin_out}, {7'h0, !p[0]});
    end
    bus(0, `ATC_OFS_CONTROL_A, 8'h00);
    chk(q, 8'h50);
    bus(0, `ATC_OFS_FLAGS, 8'h00);
    chk(q, 8'h00);
    bus(0, `ATC_OFS_COUNT, 8'h00);
    chk(q, r);
    p = {7'h0, compare_output_pin_out};
    bus(1, `ATC_OFS_CONTROL_A, 8'h68);
    repeat (3) @(posedge ref_clk_in);
    chk({7'h0, compare_output_pin_out}, p);
    $display("force done");
    bus(1, `ATC_OFS_IRQ_MASK, 8'h03);
    bus(1, `ATC_OFS_COUNT, 8'hf0 | 8'($urandom_range(15)));
    bus(1, `ATC_OFS_CONTROL_A, 8'h01);
    repeat (40) @(posedge ref_clk_in);
    bus(1, `ATC_OFS_CONTROL_A, 8'h00);
    chk({6'h0, irq_compare_out, irq_overflow_out}, 8'h03);
    $display("overflow done");
    bus(1, `ATC_OFS_IRQ_MASK, 8'h00);
    bus(1, `ATC_OFS_ASYNC_STATUS, 8'h08); // Crystal, so external clock enable stays clear
    repeat (2) @(posedge ref_clk_in);
    chk({7'h0, pad_ctl_out.port_detach}, 8'h01);
    osc_run <= 1;
    bus(1, `ATC_OFS_CONTROL_A, 8'h00);
    // Kept below the top so no overflow lands in the closing flag check
    r = 8'($urandom_range(8'he0));
    t0 = $time;
    bus(1, `ATC_OFS_COUNT, r);
    bus(0, `ATC_OFS_ASYNC_STATUS, 8'h00);
    chk(q & 8'h04, 8'h04);
    bus(1, `ATC_OFS_COMPARE, r + 8'h01);
    bus(0, `ATC_OFS_ASYNC_STATUS, 8'h00);
    chk(q & 8'h06, 8'h06);
    for (int n = 0; n < 200 && q[2:0] !== 3'h0; n++) bus(0, `ATC_OFS_ASYNC_STATUS, 8'h00);
    chk({5'h0, q[2:0]}, 8'h00);
    chk(8'(($time - t0) >= 200), 8'h01);
    bus(0, `ATC_OFS_COMPARE, 8'h00);
    chk(q, r + 8'h01);
    bus(1, `ATC_OFS_FLAGS, 8'h03);
    bus(1, `ATC_OFS_IRQ_MASK, 8'h03);
    repeat (80) @(posedge ref_clk_in);
    bus(0, `ATC_OFS_COUNT, 8'h00);
    chk(q, r);
    $display("async done");
    // Counter runs on the osc tick; the match on r + 1 must wake the block
    bus(1, `ATC_OFS_CONTROL_A, 8'h01);
    do bus(0, `ATC_OFS_ASYNC_STATUS, 8'h00); while (q[2:0] !== 3'h0);
    sleep_mode_in <= `ATC_SLEEP_POWER_SAVE;
    p = 0;
    repeat (200) @(posedge ref_clk_in) if (wake_out === 1'b1) p = 1;
    chk(p, 8'h01);
    sleep_mode_in <= `ATC_SLEEP_POWER_DOWN;
    repeat (4) @(posedge ref_clk_in);
    chk({7'h0, pad_ctl_out.osc_enable}, 8'h00);
    sleep_mode_in <= `ATC_SLEEP_NONE;
    bus(1, `ATC_OFS_FLAGS, 8'h03);
    repeat (3) @(posedge ref_clk_in);
    chk({6'h0, irq_compare_out, irq_overflow_out}, 8'h00);
    $display("wake done");
    tally_and_finish();
  end
endmodule
bind atc_timer atc_timer_asserts chk_u (.ref_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .osc_pin_in, .sleep_mode_in,
  .compare_output_pin_out, .compare_output_oe_out, .pad_ctl_out, .irq_compare_out, .irq_overflow_out, .wake_out);
